// >>> shared/csirq_defs.vh
// Constants for the card status and interrupt mask block.
// Assumes inclusion by bare name from the rtl files.
`ifndef CSIRQ_DEFS_VH
`define CSIRQ_DEFS_VH

// ************************************************************
// Register byte offsets
// ************************************************************
`define CSIRQ_OFS_PRIM   8'h00
`define CSIRQ_OFS_LIVE   8'h04
`define CSIRQ_OFS_MASK   8'h08
`define CSIRQ_OFS_CLKC   8'h0c

// ************************************************************
// Primary event status and mask bit positions
// ************************************************************
`define CSIRQ_XFER_DONE  12
`define CSIRQ_LINE3_EDGE 11
`define CSIRQ_RX_READY   10
`define CSIRQ_TX_READY   9
`define CSIRQ_RSVD_BIT   8
`define CSIRQ_RESP_CRC   7
`define CSIRQ_RD_CRC     6
`define CSIRQ_WR_CRC     5
`define CSIRQ_RESP_TOUT  4
`define CSIRQ_RD_TOUT    3
`define CSIRQ_CMD_DONE   2
`define CSIRQ_BUSY_REL   1
`define CSIRQ_DATA_DONE  0

// Writable mask bits: 12..9 and 7..0
`define CSIRQ_MASK_VALID 13'h1eff
`define CSIRQ_MASK_RST   13'h0000

// ************************************************************
// Live status bit positions
// ************************************************************
`define CSIRQ_FIFO_FULL  6
`define CSIRQ_FIFO_EMPTY 5
`define CSIRQ_LINE3_LVL  4
`define CSIRQ_RX_FULL    3
`define CSIRQ_TX_EMPTY   2
`define CSIRQ_CLK_STOP   1
`define CSIRQ_CARD_BUSY  0

// ************************************************************
// Card clock control fields and reset values
// ************************************************************
`define CSIRQ_CLKC_EN    8
`define CSIRQ_CLKC_DIV_H 7
`define CSIRQ_CLKC_EN_RST  1'b0
`define CSIRQ_CLKC_DIV_RST 8'h01

`endif

// >>> rtl/csirq_top.v
// Card status reporting and interrupt masking for a card host controller.
// Assumes primary events and FIFO/shift levels come from logic on sys_clk,
// while the card line 3 and busy indications arrive from pins.
// Registers: primary view 0x00, live status 0x04, mask 0x08, clock 0x0c.
// Read data are registered and stand for one cycle only.
//
// What this block does
// - Live status never raises the interrupt
// - Live status register is read-only
// - Bit 4 shows card line 3 level
// - Bit 3 set while receive shifter full
// - Bit 2 set while transmit shifter empty
// - Clock held low when stopped, bit 1
// - Bit 0 set while card busy detected
// - Enabled 0-to-1 status edge raises interrupt
// - Mask bit 12 enables transfer done
// - Mask bit 11 enables line 3 edge
// - Mask bit 10 enables receive ready
// - Mask bit 9 enables transmit ready
// - Mask bit 7 enables response CRC error
// - Mask bit 6 enables read CRC error
// - Mask bit 5 enables write CRC error
// - Mask bit 4 enables response time-out
// - Mask bit 3 enables read time-out
// - Mask bit 2 enables command done
// - Mask bit 1 enables busy release
// - Mask bit 0 enables data done
// - Line 3 edge flag clears on read
// - Transfer done precedes data done; bits 12 and 0 pass straight from prim_evt_in, no order enforced
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "csirq_defs.vh"

module csirq_top #(
  parameter integer DIV_W = 8
) (
  input  wire        sys_clk,
  input  wire        arst_n,
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  input  wire [12:0] prim_evt_in,
  input  wire        fifo_full_in,
  input  wire        fifo_empty_in,
  input  wire        rx_shift_full_in,
  input  wire        tx_shift_empty_in,
  input  wire        card_data_line3,
  input  wire        card_busy_pin,
  output reg         cpu_irq,
  output reg         card_clk,
  output reg         card_clock_stopped
);

  // ************************************************************
  // Address decode
  // ************************************************************

  // Exact byte address match; low bits must be zero
  function csirq_hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      csirq_hit = (addr == ofs);
    end
  endfunction

  wire wr_mask;
  wire wr_clkc;
  wire rd_prim;

  // Write decode; writes to status registers fall through
  assign wr_mask = reg_wr & csirq_hit(reg_addr, `CSIRQ_OFS_MASK);
  assign wr_clkc = reg_wr & csirq_hit(reg_addr, `CSIRQ_OFS_CLKC);
  assign rd_prim = reg_rd & csirq_hit(reg_addr, `CSIRQ_OFS_PRIM);

  // ************************************************************
  // Pin synchronisers
  // ************************************************************

  reg       line3_s1_q;
  reg       line3_s2_q;
  reg       line3_prev_q;
  reg       busy_s1_q;
  reg       busy_s2_q;
  reg [1:0] line3_fill_q;

  // Two stages before use; only the second stage is read
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      line3_s1_q   <= 1'b0;
      line3_s2_q   <= 1'b0;
      line3_prev_q <= 1'b0;
      busy_s1_q    <= 1'b0;
      busy_s2_q    <= 1'b0;
    end
    else
    begin
      line3_s1_q   <= card_data_line3;
      line3_s2_q   <= line3_s1_q;
      line3_prev_q <= line3_s2_q;
      busy_s1_q    <= card_busy_pin;
      busy_s2_q    <= busy_s1_q;
    end
  end

  // Edges count only once both stages and the compare copy hold real
  // pin samples; a pin that idles high would otherwise fake an edge
  // right after release of reset
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      line3_fill_q <= 2'b00;
    end
    else if (line3_fill_q != 2'b11)
    begin
      line3_fill_q <= line3_fill_q + 2'b01;
    end
  end

  // ************************************************************
  // Line 3 edge flag
  // ************************************************************

  reg  line3_edge_q;
  reg  line3_edge_d;
  wire line3_edge_seen;

  // Either direction counts; edges in the first three cycles after
  // release are not seen, the price of no false edge from a high pin
  assign line3_edge_seen = (line3_s2_q ^ line3_prev_q) & (line3_fill_q == 2'b11);

  // Set wins over the read clear so no edge is lost
  always @*
  begin
    line3_edge_d = line3_edge_q;
    if (rd_prim)
    begin
      line3_edge_d = 1'b0;
    end
    if (line3_edge_seen)
    begin
      line3_edge_d = 1'b1;
    end
  end

  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      line3_edge_q <= 1'b0;
    end
    else
    begin
      line3_edge_q <= line3_edge_d;
    end
  end

  // ************************************************************
  // Interrupt mask register
  // ************************************************************

  reg [12:0] mask_q;

  // Only documented enables are stored; reserved bits stay zero
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mask_q <= `CSIRQ_MASK_RST;
    end
    else if (wr_mask)
    begin
      mask_q <= reg_wdata[12:0] & `CSIRQ_MASK_VALID;
    end
  end

  // ************************************************************
  // Primary status view and interrupt edge detection
  // ************************************************************

  reg  [12:0] prim_vec;
  reg  [12:0] prim_prev_q;
  wire [12:0] prim_rise;

  // Edge flag is ours; transfer done and data done are separate inputs
  always @*
  begin
    prim_vec = prim_evt_in;
    prim_vec[`CSIRQ_LINE3_EDGE] = line3_edge_q;
    prim_vec[`CSIRQ_RSVD_BIT]   = 1'b0;
  end

  // Previous copy gives the 0-to-1 transition per source
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      prim_prev_q <= 13'h0000;
    end
    else
    begin
      prim_prev_q <= prim_vec;
    end
  end

  // A mask bit of 0 blocks its source; live status is not a source
  assign prim_rise = prim_vec & ~prim_prev_q & mask_q;

  // Interrupt is a one-cycle pulse per cycle in which any enabled source rises
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cpu_irq <= 1'b0;
    end
    else
    begin
      cpu_irq <= |prim_rise;
    end
  end

  // ************************************************************
  // Card clock control
  // ************************************************************

  reg             clk_en_q;
  reg [DIV_W-1:0] clk_div_q;
  reg [DIV_W-1:0] clk_cnt_q;
  reg [DIV_W-1:0] clk_cnt_d;
  reg             card_clk_d;
  wire            clk_stop;

  // Enable and divider, written by software
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      clk_en_q  <= `CSIRQ_CLKC_EN_RST;
      clk_div_q <= `CSIRQ_CLKC_DIV_RST;
    end
    else if (wr_clkc)
    begin
      clk_en_q  <= reg_wdata[`CSIRQ_CLKC_EN];
      clk_div_q <= reg_wdata[DIV_W-1:0];
    end
  end

  // Stop on manual disable or when the shifters cannot move data
  assign clk_stop = ~clk_en_q | rx_shift_full_in | tx_shift_empty_in;

  // Half period is div+1 system cycles; restart from low after a stop
  always @*
  begin
    clk_cnt_d  = clk_cnt_q;
    card_clk_d = card_clk;
    if (clk_stop)
    begin
      clk_cnt_d  = {DIV_W{1'b0}};
      card_clk_d = 1'b0;
    end
    else if (clk_cnt_q == clk_div_q)
    begin
      clk_cnt_d  = {DIV_W{1'b0}};
      card_clk_d = ~card_clk;
    end
    else
    begin
      clk_cnt_d = clk_cnt_q + {{(DIV_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      clk_cnt_q          <= {DIV_W{1'b0}};
      card_clk           <= 1'b0;
      card_clock_stopped <= 1'b1;
    end
    else
    begin
      clk_cnt_q          <= clk_cnt_d;
      card_clk           <= card_clk_d;
      card_clock_stopped <= clk_stop;
    end
  end

  // ************************************************************
  // Live status register
  // ************************************************************

  reg [6:0] live_q;

  // Sampled every cycle from hardware; no write path exists
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      live_q <= 7'h00;
    end
    else
    begin
      live_q[`CSIRQ_FIFO_FULL]  <= fifo_full_in;
      live_q[`CSIRQ_FIFO_EMPTY] <= fifo_empty_in;
      live_q[`CSIRQ_LINE3_LVL]  <= line3_s2_q;
      live_q[`CSIRQ_RX_FULL]    <= rx_shift_full_in;
      live_q[`CSIRQ_TX_EMPTY]   <= tx_shift_empty_in;
      live_q[`CSIRQ_CLK_STOP]   <= clk_stop;
      live_q[`CSIRQ_CARD_BUSY]  <= busy_s2_q;
    end
  end

  // ************************************************************
  // Read path
  // ************************************************************

  reg [31:0] rdata_d;

  // Data stand only in the cycle after the strobe, zero otherwise
  always @*
  begin
    rdata_d = 32'h00000000;
    if (reg_rd)
    begin
      case (reg_addr)
        `CSIRQ_OFS_PRIM:
        begin
          rdata_d[12:0] = prim_vec;
        end
        `CSIRQ_OFS_LIVE:
        begin
          rdata_d[6:0] = live_q;
        end
        `CSIRQ_OFS_MASK:
        begin
          rdata_d[12:0] = mask_q;
        end
        `CSIRQ_OFS_CLKC:
        begin
          rdata_d[`CSIRQ_CLKC_EN] = clk_en_q;
          rdata_d[DIV_W-1:0]      = clk_div_q;
        end
        default:
        begin
          rdata_d = 32'h00000000;
        end
      endcase
    end
  end

  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reg_rdata <= 32'h00000000;
    end
    else
    begin
      reg_rdata <= rdata_d;
    end
  end

endmodule

`default_nettype wire

// >>> test/csirq_cpu_model.sv
// CPU side model: counts interrupt pulses.
// Assumes cpu_irq is a one-cycle pulse on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module csirq_cpu_model (
  input  wire logic sys_clk,
  input  wire logic arst_n,
  input  wire logic cpu_irq,
  output var  int   irq_cnt
);
  // Edge-taken input, so each high cycle is one event
  always @(posedge sys_clk or negedge arst_n)
    if (!arst_n)
      irq_cnt <= 0;
    else if (cpu_irq === 1'b1)
      irq_cnt <= irq_cnt + 1;
endmodule
`default_nettype wire

// >>> test/csirq_top_asserts.sv
// Checker for the card status and irq mask block.
// Assumes one clock domain; bound onto csirq_top below.
`timescale 1ns/1ps
`default_nettype none
module csirq_chk (
  input wire logic        sys_clk,
  input wire logic        arst_n,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [12:0] prim_evt_in,
  input wire logic        fifo_full_in,
  input wire logic        fifo_empty_in,
  input wire logic        rx_shift_full_in,
  input wire logic        tx_shift_empty_in,
  input wire logic        cpu_irq,
  input wire logic        card_clk,
  input wire logic        card_clock_stopped
);
  logic [12:0] mask_q;
  logic [12:0] prim_q;
  logic [3:0]  lvl;
  wire  [12:0] rise = prim_evt_in & ~prim_q & mask_q & 13'h16ff;
  assign lvl = {fifo_full_in, fifo_empty_in, rx_shift_full_in, tx_shift_empty_in};
  // Shadow mask, as the checker only sees the bus
  always_ff @(posedge sys_clk or negedge arst_n)
    if (!arst_n)
    begin
      mask_q <= 13'h0000;
      prim_q <= 13'h0000;
    end
    else
    begin
      prim_q <= prim_evt_in;
      if (reg_wr && reg_addr == 8'h08)
        mask_q <= reg_wdata[12:0] & 13'h1eff;
    end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  AST_IRQ_RISE: assert property (|rise |=> cpu_irq)
    else $error("irq missing");
  AST_IRQ_QUIET: assert property (rise == 13'h0 && !mask_q[11] |=> !cpu_irq)
    else $error("irq without cause");
  AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("rdata not idle");
  AST_LIVE_RD: assert property (reg_rd && reg_addr == 8'h04 && $stable(lvl) |=>
    reg_rdata[31:5] == {25'h0, $past(lvl[3:2])} && reg_rdata[3:2] == $past(lvl[1:0]))
    else $error("live status wrong");
  AST_MASK_RD: assert property (reg_rd && reg_addr == 8'h08 |=>
    reg_rdata == {19'h0, mask_q})
    else $error("mask readback wrong");
  AST_UNMAPPED: assert property (reg_rd && reg_addr > 8'h0c |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  AST_CLK_STOP: assert property (rx_shift_full_in || tx_shift_empty_in |=>
    card_clock_stopped && !card_clk)
    else $error("card clock not stopped");
  AST_STOP_LOW: assert property (card_clock_stopped |-> !card_clk)
    else $error("stopped clock high");
endmodule
bind csirq_top csirq_chk csirq_chk_inst (.sys_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .prim_evt_in, .fifo_full_in, .fifo_empty_in, .rx_shift_full_in,
  .tx_shift_empty_in, .cpu_irq, .card_clk, .card_clock_stopped);
`default_nettype wire

// >>> test/csirq_top_test.sv
// Bench for the card status and irq mask block.
// Assumes the design, checker and CPU model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module csirq_top_test;
  logic        sys_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [12:0] prim = 13'h0000;
  logic [3:0]  lvl = 4'h0;
  logic        line3 = 1'b0;
  logic        busy = 1'b0;
  logic        cpu_irq, card_clk, card_clock_stopped;
  int          irq_cnt, n, b, fails = 0, checks = 0;
  always #5 sys_clk = ~sys_clk;
  csirq_top csirq_top_inst (.sys_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .prim_evt_in(prim), .fifo_full_in(lvl[3]), .fifo_empty_in(lvl[2]),
    .rx_shift_full_in(lvl[1]), .tx_shift_empty_in(lvl[0]), .card_data_line3(line3),
    .card_busy_pin(busy), .cpu_irq, .card_clk, .card_clock_stopped);
  csirq_cpu_model csirq_cpu_model_inst (.sys_clk, .arst_n, .cpu_irq, .irq_cnt);
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk("rdata", exp, reg_rdata);
    // End on an edge so that stimulus after a read stays edge-aligned
    @(posedge sys_clk);
  endtask
  // One rise of the event bits p, then count the pulses
  task automatic pulse(input logic [12:0] p, input int exp);
    n = irq_cnt;
    @(posedge sys_clk);
    prim <= p;
    tick(3);
    prim <= 13'h0000;
    tick(1);
    chk("irq", exp, irq_cnt - n);
  endtask
  task automatic conclude;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Hang guard
  initial
  begin
    #200000;
    fails++;
    conclude;
  end
  // *****
  // Tests
  // *****
  initial
  begin
    tick(3);
    arst_n <= 1'b1;
    rd(8'h08, 32'h0);
    rd(8'h10, 32'h0);
    wr(8'h08, 32'hffffffff);
    rd(8'h08, 32'h00001eff);
    for (b = 0; b < 13; b++)
      if (b != 8 && b != 11)
      begin
        wr(8'h08, 32'h1 << b);
        pulse(~(13'h1 << b), 0);
        pulse(13'h1 << b, 1);
      end
    $display("mask test done");
    wr(8'h08, 32'h800);
    n = irq_cnt;
    line3 <= 1'b1;
    tick(8);
    chk("irq", 1, irq_cnt - n);
    rd(8'h00, 32'h800);
    rd(8'h00, 32'h0);
    $display("edge test done");
    wr(8'h08, 32'h16ff);
    n = irq_cnt;
    for (b = 0; b < 2; b++)
    begin
      lvl <= b ? 4'h5 : 4'ha;
      line3 <= b[0];
      busy <= !b;
      tick(6);
      rd(8'h04, {25'h0, lvl[3:2], line3, lvl[1:0], 1'b1, busy});
      wr(8'h04, 32'h0);
      rd(8'h04, {25'h0, lvl[3:2], line3, lvl[1:0], 1'b1, busy});
    end
    chk("irq", 0, irq_cnt - n);
    lvl <= 4'h0;
    wr(8'h0c, 32'h101);
    rd(8'h0c, 32'h101);
    tick(4);
    rd(8'h04, 32'h10);
    chk("stop", 32'h0, {31'h0, card_clock_stopped});
    n = 0;
    repeat (40)
    begin
      @(posedge sys_clk);
      #1 n += (card_clk === 1'b1);
    end
    chk("clk", 20, n);
    @(posedge sys_clk);
    lvl <= 4'h1;
    tick(3);
    rd(8'h04, 32'h16);
    chk("stop", 32'h1, {31'h0, card_clock_stopped});
    chk("clk", 32'h0, {31'h0, card_clk});
    $display("live test done");
    conclude;
  end
endmodule
`default_nettype wire
